// [core/i2csp_cfg.svh]
`ifndef I2CSP_CFG_SVH
`define I2CSP_CFG_SVH
// register indices on the plain port
`define I2CSP_OFS_CTRL    3'h0
`define I2CSP_OFS_STAT    3'h1
`define I2CSP_OFS_BUF     3'h2
`define I2CSP_OFS_ADDR    3'h3
`define I2CSP_OFS_IRQF    3'h4
`define I2CSP_OFS_IRQE    3'h5
`define I2CSP_OFS_MASK    3'h6
// control field positions
`define I2CSP_CTRL_WRITE_COLLISION   7
`define I2CSP_CTRL_OV     6
`define I2CSP_CTRL_EN     5
`define I2CSP_CTRL_CKP    4
// status field positions
`define I2CSP_STAT_DA     5
`define I2CSP_STAT_P      4
`define I2CSP_STAT_S      3
`define I2CSP_STAT_RW     2
`define I2CSP_STAT_UA     1
`define I2CSP_STAT_BF     0
// flag/enable bit for the serial port
`define I2CSP_IRQ_SER     3
// reset values
`define I2CSP_RST_CTRL    8'h00
`define I2CSP_RST_STAT    8'h00
`define I2CSP_RST_IRQ     8'h00
`define I2CSP_RST_ADDR    8'h00
`define I2CSP_RST_MASK    8'hFF
// 10-bit header prefix
`define I2CSP_HDR10       5'h1E
// mode codes
`define I2CSP_M_S7        4'h6
`define I2CSP_M_S10       4'h7
`define I2CSP_M_MST       4'h8
`define I2CSP_M_FW        4'hB
`define I2CSP_M_S7SP      4'hE
`define I2CSP_M_S10SP     4'hF
`endif

// [core/i2csp_pkg.sv]
package i2csp_pkg;
  typedef enum logic [2:0] {
    I2CSP_IDLE = 3'b000,
    I2CSP_RXB  = 3'b001,
    I2CSP_ACK  = 3'b010,
    I2CSP_TXB  = 3'b011,
    I2CSP_MACK = 3'b100,
    I2CSP_SKIP = 3'b101
  } i2csp_state_e;

  typedef struct packed {
    logic       scl_i;
    logic       sda_i;
  } i2csp_pins_in_s;

  typedef struct packed {
    logic       scl_o;
    logic       scl_oe;
    logic       sda_o;
    logic       sda_oe;
  } i2csp_pins_out_s;

  typedef struct packed {
    logic       scl_q;
    logic       sda_q;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
  } i2csp_edge_s;
endpackage

// [core/i2csp_edges.sv]
`timescale 1ns/1ps
module i2csp_edges
  import i2csp_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst,
  input  i2csp_pins_in_s      pins,
  output i2csp_edge_s         ev
);
  typedef struct packed {
    logic scl;
    logic sda;
    logic prev_scl;
    logic prev_sda;
  } i2csp_eg_s;

  i2csp_eg_s st_q;
  i2csp_eg_s st_d;

  always_comb begin
    st_d          = st_q;
    st_d.prev_scl = st_q.scl;
    st_d.prev_sda = st_q.sda;
    st_d.scl      = pins.scl_i;
    st_d.sda      = pins.sda_i;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '{scl: 1'b1, sda: 1'b1, prev_scl: 1'b1, prev_sda: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  // start/stop only while scl stays high
  always_comb begin
    ev.scl_q = st_q.scl;
    ev.sda_q = st_q.sda;
    ev.rise  = st_q.scl & ~st_q.prev_scl;
    ev.fall  = ~st_q.scl & st_q.prev_scl;
    ev.start = st_q.scl & st_q.prev_scl & st_q.prev_sda & ~st_q.sda;
    ev.stop  = st_q.scl & st_q.prev_scl & ~st_q.prev_sda & st_q.sda;
  end
endmodule

// [core/i2csp_top.sv]
// Notes on behaviour
// - no serial function until enable bit set
// - pins driven only as open drain
// - mode field: 7/10-bit slaves; master and firmware codes leave the port idle
// - after start, shift eight bits on rise
// - compare shift bits 7:1 at eighth fall
// - match: load buffer, set full, ack, flag
// - auto ack and buffer load per byte
// - full or overflow: no ack, keep buffer, flag
// - buffer read clears full; overflow by software
// - 11110 prefix marks a 10-bit header
// - high byte: flag, full, update, hold scl
// - low byte: flag, full, update, hold scl
// - repeated-start header sets flag and full, no update; read also holds scl
// - direction bit copied to read/write status
// - flag raised for each byte that reaches the ack slot; skipped bytes raise none
// - read match: ack, hold scl till release
// - buffer write while held in transmit also loads shift register
// - transmit bits change on scl falling edges
// - transmit flag at ninth falling edge
// - master nack at ninth rise ends transfer
// - slave drives data itself when transmitting
`timescale 1ns/1ps
`include "i2csp_cfg.svh"
module i2csp_top
  import i2csp_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic [2:0]     addr,
  input  wire logic [7:0]     wdata,
  input  wire logic           wr,
  input  wire logic           rd,
  output logic      [7:0]     rdata,
  input  i2csp_pins_in_s      pins,
  output i2csp_pins_out_s     pins_out
);
  typedef struct packed {
    i2csp_state_e st;
    logic [7:0]   ctrl;
    logic [7:0]   stat;
    logic [7:0]   buf_r;
    logic [7:0]   sr;
    logic [7:0]   own;
    logic [7:0]   msk;
    logic [7:0]   irqf;
    logic [7:0]   irqe;
    logic [3:0]   bits;
    logic         do_ack;
    logic         tenbit;
    logic         hdr_seen;
    logic         low_ok;
    logic         low_rx;
    logic         tx_mode;
    logic         hold;
    logic         sda_lo;
    logic         scl_lo;
    logic [7:0]   rdata;
  } i2csp_st_s;

  i2csp_st_s   q;
  i2csp_st_s   d;
  i2csp_edge_s ev;

  i2csp_edges u_edges (
    .clk  (clk),
    .rst  (rst),
    .pins (pins),
    .ev   (ev)
  );

  function automatic logic mode_slave(input logic [3:0] m);
    mode_slave = (m == `I2CSP_M_S7) || (m == `I2CSP_M_S10) ||
                 (m == `I2CSP_M_S7SP) || (m == `I2CSP_M_S10SP);
  endfunction

  function automatic logic mode_ten(input logic [3:0] m);
    mode_ten = (m == `I2CSP_M_S10) || (m == `I2CSP_M_S10SP);
  endfunction

  function automatic logic addr_eq(input logic [6:0] a, input logic [6:0] b,
                                   input logic [6:0] m);
    addr_eq = ((a ^ b) & m) == 7'h00;
  endfunction

  function automatic logic byte_eq(input logic [7:0] a, input logic [7:0] b,
                                   input logic [7:0] m);
    byte_eq = ((a ^ b) & m) == 8'h00;
  endfunction

  logic enabled;
  logic slave;
  logic full_or_ov;

  always_comb begin
    enabled    = q.ctrl[`I2CSP_CTRL_EN];
    slave      = enabled && mode_slave(q.ctrl[3:0]);
    full_or_ov = q.stat[`I2CSP_STAT_BF] | q.ctrl[`I2CSP_CTRL_OV];
  end

  always_comb begin
    d = q;
    d.rdata = 8'h00;
    // register port; reads answer one cycle later
    if (rd) begin
      unique case (addr)
        `I2CSP_OFS_CTRL: d.rdata = q.ctrl;
        `I2CSP_OFS_STAT: d.rdata = q.stat;
        `I2CSP_OFS_BUF: begin
          d.rdata = q.buf_r;
          d.stat[`I2CSP_STAT_BF] = 1'b0;
        end
        `I2CSP_OFS_ADDR: d.rdata = q.own;
        `I2CSP_OFS_IRQF: d.rdata = q.irqf;
        `I2CSP_OFS_IRQE: d.rdata = q.irqe;
        `I2CSP_OFS_MASK: d.rdata = q.msk;
        default: d.rdata = 8'h00;
      endcase
    end
    if (wr) begin
      unique case (addr)
        `I2CSP_OFS_CTRL: begin
          d.ctrl = wdata; // overflow only cleared here
          if (wdata[`I2CSP_CTRL_CKP]) begin
            d.hold = 1'b0;
          end
        end
        `I2CSP_OFS_BUF: begin
          if (q.tx_mode && q.st == I2CSP_TXB && q.bits == 4'h0 && q.hold) begin
            d.buf_r = wdata;
            d.sr    = wdata;
          end else if (q.tx_mode && q.hold) begin
            d.buf_r = wdata;
            d.sr    = wdata;
          end else if (q.st == I2CSP_TXB || q.st == I2CSP_MACK) begin
            // a write while bits are moving is dropped and flagged
            d.ctrl[`I2CSP_CTRL_WRITE_COLLISION] = 1'b1;
          end else begin
            d.buf_r = wdata;
          end
        end
        `I2CSP_OFS_ADDR: begin
          d.own = wdata;
          // a write while UA is set frees scl; software owns the match
          if (q.stat[`I2CSP_STAT_UA]) begin
            d.stat[`I2CSP_STAT_UA] = 1'b0;
            d.hold = 1'b0;
          end
        end
        `I2CSP_OFS_IRQF: d.irqf = wdata & 8'h7F;
        `I2CSP_OFS_IRQE: d.irqe = wdata & 8'h7F;
        `I2CSP_OFS_MASK: d.msk = wdata;
        default: d.rdata = d.rdata;
      endcase
    end

    if (!slave) begin
      // disabling drops any transfer in flight
      d.st = I2CSP_IDLE;
      d.hold = 1'b0;
      d.sda_lo = 1'b0;
      d.tx_mode = 1'b0;
      d.stat[`I2CSP_STAT_S] = 1'b0;
      d.stat[`I2CSP_STAT_P] = 1'b0;
    end else if (ev.start) begin
      d.st = I2CSP_RXB;
      d.bits = 4'h0;
      d.sda_lo = 1'b0;
      d.tx_mode = 1'b0;
      d.tenbit = 1'b0;
      d.stat[`I2CSP_STAT_S] = 1'b1;
      d.stat[`I2CSP_STAT_P] = 1'b0;
      d.stat[`I2CSP_STAT_DA] = 1'b0;
      if (q.ctrl[3:0] == `I2CSP_M_S7SP || q.ctrl[3:0] == `I2CSP_M_S10SP) begin
        d.irqf[`I2CSP_IRQ_SER] = 1'b1;
      end
    end else if (ev.stop) begin
      d.st = I2CSP_IDLE;
      d.sda_lo = 1'b0;
      d.hdr_seen = 1'b0;
      d.low_ok = 1'b0;
      d.stat[`I2CSP_STAT_P] = 1'b1;
      d.stat[`I2CSP_STAT_S] = 1'b0;
      if (q.ctrl[3:0] == `I2CSP_M_S7SP || q.ctrl[3:0] == `I2CSP_M_S10SP) begin
        d.irqf[`I2CSP_IRQ_SER] = 1'b1;
      end
    end else begin
      unique case (q.st)
        I2CSP_IDLE, I2CSP_SKIP: d.st = q.st;
        I2CSP_RXB: begin
          if (ev.rise) begin
            d.sr = {q.sr[6:0], ev.sda_q};
            d.bits = q.bits + 4'h1;
          end
          if (ev.fall && q.bits == 4'h8) begin
            d.st = I2CSP_ACK;
            d.do_ack = 1'b0;
            if (q.stat[`I2CSP_STAT_DA]) begin
              d.do_ack = !full_or_ov;
              if (full_or_ov) begin
                d.ctrl[`I2CSP_CTRL_OV] = 1'b1;
              end else begin
                d.buf_r = q.sr;
              end
            end else if (mode_ten(q.ctrl[3:0]) && q.hdr_seen &&
                         !q.low_ok) begin
              // low byte tested first, so one starting 11110 is not
              // mistaken for a header
              d.low_rx = 1'b1;
              if (byte_eq(q.sr, q.own, q.msk)) begin
                d.do_ack = !full_or_ov;
                d.tenbit = 1'b1;
                if (!full_or_ov) begin
                  d.buf_r = q.sr;
                end
              end else begin
                d.hdr_seen = 1'b0;
                d.st = I2CSP_SKIP;
              end
            end else if (mode_ten(q.ctrl[3:0]) &&
                         q.sr[7:3] == `I2CSP_HDR10) begin
              d.low_rx = 1'b0;
              if (q.sr[2:1] == q.own[2:1] && (!q.sr[0] || q.low_ok)) begin
                d.do_ack = !full_or_ov;
                d.tenbit = !q.sr[0];
                d.hdr_seen = 1'b1;
                d.stat[`I2CSP_STAT_RW] = q.sr[0];
                if (!full_or_ov) begin
                  d.buf_r = q.sr;
                end
              end else begin
                d.st = I2CSP_SKIP;
              end
            end else if (!mode_ten(q.ctrl[3:0]) &&
                         addr_eq(q.sr[7:1], q.own[7:1], q.msk[7:1])) begin
              d.do_ack = !full_or_ov;
              d.stat[`I2CSP_STAT_RW] = q.sr[0];
              if (!full_or_ov) begin
                d.buf_r = q.sr;
              end
            end else begin
              d.st = I2CSP_SKIP;
            end
            if (d.st == I2CSP_ACK) begin
              d.sda_lo = d.do_ack;
              if (!full_or_ov) begin
                d.stat[`I2CSP_STAT_BF] = 1'b1;
              end else begin
                d.ctrl[`I2CSP_CTRL_OV] = 1'b1;
              end
            end
          end
        end
        I2CSP_ACK: begin
          if (ev.fall) begin
            d.sda_lo = 1'b0;
            d.bits = 4'h0;
            d.irqf[`I2CSP_IRQ_SER] = 1'b1;
            d.st = I2CSP_RXB;
            if (q.stat[`I2CSP_STAT_DA]) begin
              d.st = I2CSP_RXB;
            end else if (q.tenbit && !q.low_ok && q.do_ack) begin
              d.stat[`I2CSP_STAT_UA] = 1'b1;
              d.hold = 1'b1;
              if (q.low_rx) begin
                d.low_ok = 1'b1;
                d.stat[`I2CSP_STAT_DA] = 1'b1;
              end
            end else if (q.stat[`I2CSP_STAT_RW] && q.do_ack) begin
              d.tx_mode = 1'b1;
              d.hold = 1'b1;
              d.st = I2CSP_TXB;
              d.stat[`I2CSP_STAT_DA] = 1'b1;
            end else if (q.do_ack) begin
              d.stat[`I2CSP_STAT_DA] = 1'b1;
            end else begin
              d.st = I2CSP_SKIP;
            end
            if (q.tx_mode) begin
              d.st = I2CSP_TXB;
            end
          end
        end
        I2CSP_TXB: begin
          // first bit goes out while scl is still held, so it has
          // settled long before the master raises scl again
          d.sda_lo = !q.sr[7];
          if (ev.fall && !q.hold) begin
            d.sr = {q.sr[6:0], 1'b1};
            d.bits = q.bits + 4'h1;
            if (q.bits == 4'h7) begin
              d.st = I2CSP_MACK;
              d.sda_lo = 1'b0;
            end
          end
        end
        I2CSP_MACK: begin
          d.sda_lo = 1'b0;
          if (ev.rise) begin
            d.do_ack = !ev.sda_q;
          end
          if (ev.fall) begin
            d.irqf[`I2CSP_IRQ_SER] = 1'b1;
            d.bits = 4'h0;
            if (q.do_ack) begin
              d.st = I2CSP_TXB;
              d.hold = 1'b1;
            end else begin
              d.st = I2CSP_IDLE;
              d.tx_mode = 1'b0;
            end
          end
        end
        default: d.st = I2CSP_IDLE;
      endcase
    end
    // scl held low only during its low phase; master waits
    d.scl_lo = slave && d.hold && !ev.scl_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= I2CSP_IDLE;
      q.ctrl <= `I2CSP_RST_CTRL;
      q.stat <= `I2CSP_RST_STAT;
      q.own <= `I2CSP_RST_ADDR;
      q.msk <= `I2CSP_RST_MASK;
      q.irqf <= `I2CSP_RST_IRQ;
      q.irqe <= `I2CSP_RST_IRQ;
    end else begin
      q <= d;
    end
  end

  // open drain only: drive low or release
  always_comb begin
    rdata           = q.rdata;
    pins_out.scl_o  = 1'b0;
    pins_out.sda_o  = 1'b0;
    pins_out.scl_oe = q.scl_lo;
    pins_out.sda_oe = q.sda_lo;
  end
endmodule

// [testbench/i2csp_top_checker.sv]
`timescale 1ns/1ps
`include "i2csp_cfg.svh"
module i2csp_checker
  import i2csp_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst,
  input wire logic [2:0]      addr,
  input wire logic [7:0]      wdata,
  input wire logic            wr,
  input wire logic            rd,
  input wire logic [7:0]      rdata,
  input wire i2csp_pins_in_s  pins,
  input wire i2csp_pins_out_s pins_out
);
  logic [7:0] irqe_q;
  logic [2:0] wr_q;
  // release may lag the write by a few flops
  always_ff @(posedge clk) begin
    wr_q <= {wr_q[1:0], wr};
    if (rst) begin
      irqe_q <= 8'h00;
    end else if (wr && addr == `I2CSP_OFS_IRQE) begin
      irqe_q <= wdata & 8'h7F;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  od_low_a: assert property (!pins_out.scl_o && !pins_out.sda_o)
    else $error("pin driven high");
  rst_idle_a: assert property ($fell(rst) |->
    !pins_out.scl_oe && !pins_out.sda_oe && rdata == 8'h00)
    else $error("busy after reset");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data without read");
  irqe_rw_a: assert property (rd && addr == `I2CSP_OFS_IRQE
    |=> rdata == irqe_q)
    else $error("irq enable readback");
  unmapped_a: assert property (rd && addr == 3'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  hold_start_a: assert property ($rose(pins_out.scl_oe)
    |-> $past(!pins.scl_i))
    else $error("scl pulled while high");
  sda_change_a: assert property ($changed(pins_out.sda_oe)
    |-> !pins.scl_i)
    else $error("sda moved while scl high");
  release_src_a: assert property ($fell(pins_out.scl_oe)
    |-> wr_q != 3'h0)
    else $error("scl freed without write");
endmodule

// [testbench/i2csp_master_model.sv]
`timescale 1ns/1ps
module i2csp_master_model (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe,
  output logic      stuck
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    stuck = 1'b0;
  end
  task automatic qw();
    repeat (8) @(posedge clk);
  endtask
  // wait out a stretch, bounded so a stuck slave cannot hang us
  task automatic sclhi();
    int n;
    n = 0;
    scl_oe <= 1'b0;
    @(posedge clk);
    while (!scl && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (!scl)
      stuck <= 1'b1;
    qw();
  endtask
  task automatic start();
    sda_oe <= 1'b0;
    qw();
    sclhi();
    sda_oe <= 1'b1;
    qw();
    scl_oe <= 1'b1;
    qw();
  endtask
  task automatic stop();
    sda_oe <= 1'b1;
    qw();
    sclhi();
    sda_oe <= 1'b0;
    qw();
  endtask
  // msb first; ninth slot sends a and returns the line level
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic nak);
    logic [8:0] s;
    logic [8:0] r;
    s = {d, a};
    for (int i = 8; i >= 0; i--) begin
      sda_oe <= !s[i];
      qw();
      sclhi();
      r[i] = sda;
      qw();
      scl_oe <= 1'b1;
      qw();
    end
    q = r[8:1];
    nak = r[0];
  endtask
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
`include "i2csp_cfg.svh"
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end
module tb
  import i2csp_pkg::*;
;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic [2:0]      addr = 3'h0;
  logic [7:0]      wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic [7:0]      rdata;
  i2csp_pins_in_s  pins;
  i2csp_pins_out_s pins_out;
  logic            m_scl_oe;
  logic            m_sda_oe;
  logic            stuck;
  int              errors = 0;
  int              samples_checked = 0;
  logic [6:0]      sa;
  logic [7:0]      v, q, tx, d1, hi, lo;
  logic            ack;
  always #2.5 clk = ~clk;
  // open drain with pull-up: low when anyone pulls
  assign pins = '{scl_i: !(m_scl_oe || pins_out.scl_oe),
                  sda_i: !(m_sda_oe || pins_out.sda_oe)};
  i2csp_top DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pins(pins), .pins_out(pins_out));
  i2csp_master_model m (.clk(clk), .scl(pins.scl_i), .sda(pins.sda_i),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .stuck(stuck));
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic cr(input logic [2:0] a, input logic [7:0] mk,
                    input logic [7:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    `CHK(nm, e, v & mk)
  endtask
  task automatic wb(input logic [7:0] d, output logic a);
    logic [7:0] r;
    m.xfer(d, 1'b1, r, a);
    a = !a;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(87));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cr(`I2CSP_OFS_CTRL, 8'hFF, 8'h00, "ctrl");
    cr(`I2CSP_OFS_STAT, 8'hFF, 8'h00, "stat");
    cr(`I2CSP_OFS_IRQF, 8'hFF, 8'h00, "irqf");
    cr(`I2CSP_OFS_IRQE, 8'hFF, 8'h00, "irqe");
    cr(`I2CSP_OFS_MASK, 8'hFF, 8'hFF, "mask");
    cr(3'h7, 8'hFF, 8'h00, "unmapped");
    tx = 8'($urandom);
    wreg(`I2CSP_OFS_IRQE, tx);
    cr(`I2CSP_OFS_IRQE, 8'hFF, tx & 8'h7F, "irqe rw");
    $display("regs done");
    sa = 7'h10 + 7'($urandom % 64);
    wreg(`I2CSP_OFS_ADDR, {sa, 1'b0});
    m.start();
    wb({sa, 1'b0}, ack);
    `CHK("ack off", 1'b0, ack)
    m.stop();
    wreg(`I2CSP_OFS_CTRL, 8'h36);
    m.start();
    wb({sa, 1'b0}, ack);
    `CHK("ack adr", 1'b1, ack)
    cr(`I2CSP_OFS_STAT, 8'h07, 8'h01, "stat adr");
    cr(`I2CSP_OFS_IRQF, 8'h08, 8'h08, "flag adr");
    cr(`I2CSP_OFS_BUF, 8'hFF, {sa, 1'b0}, "buf adr");
    cr(`I2CSP_OFS_STAT, 8'h01, 8'h00, "full clr");
    wreg(`I2CSP_OFS_IRQF, 8'h00);
    d1 = 8'($urandom);
    wb(d1, ack);
    `CHK("ack d1", 1'b1, ack)
    cr(`I2CSP_OFS_IRQF, 8'h08, 8'h08, "flag d1");
    wreg(`I2CSP_OFS_IRQF, 8'h00);
    wb(~d1, ack);
    `CHK("ack full", 1'b0, ack)
    cr(`I2CSP_OFS_IRQF, 8'h08, 8'h08, "flag full");
    cr(`I2CSP_OFS_BUF, 8'hFF, d1, "buf kept");
    wreg(`I2CSP_OFS_CTRL, 8'h36);
    wb(d1 ^ 8'h5A, ack);
    `CHK("ack ovf clr", 1'b1, ack)
    cr(`I2CSP_OFS_BUF, 8'hFF, d1 ^ 8'h5A, "buf new");
    m.stop();
    $display("write done");
    wreg(`I2CSP_OFS_IRQF, 8'h00);
    m.start();
    wb({sa ^ 7'h01, 1'b0}, ack);
    `CHK("ack miss", 1'b0, ack)
    wb(d1, ack);
    `CHK("ack skip", 1'b0, ack)
    cr(`I2CSP_OFS_IRQF, 8'h08, 8'h00, "flag miss");
    m.stop();
    $display("miss done");
    m.start();
    wb({sa, 1'b1}, ack);
    `CHK("ack rd", 1'b1, ack)
    tx = 8'($urandom);
    fork
      m.xfer(8'hFF, 1'b1, q, ack);
      begin
        repeat (60) @(posedge clk);
        `CHK("scl held", 1'b1, pins_out.scl_oe)
        cr(`I2CSP_OFS_STAT, 8'h07, 8'h05, "stat rd");
        cr(`I2CSP_OFS_BUF, 8'hFF, {sa, 1'b1}, "buf rd");
        wreg(`I2CSP_OFS_IRQF, 8'h00);
        wreg(`I2CSP_OFS_BUF, tx);
        wreg(`I2CSP_OFS_CTRL, 8'h36);
      end
    join
    `CHK("tx data", tx, q)
    `CHK("ack slot", 1'b1, ack)
    cr(`I2CSP_OFS_IRQF, 8'h08, 8'h08, "flag tx");
    `CHK("sda free", 1'b0, pins_out.sda_oe)
    m.stop();
    $display("read done");
    hi = {5'h1E, 2'($urandom), 1'b0};
    lo = 8'($urandom);
    wreg(`I2CSP_OFS_CTRL, 8'h37);
    wreg(`I2CSP_OFS_ADDR, hi);
    m.start();
    wb(hi, ack);
    `CHK("ack hdr", 1'b1, ack)
    fork
      wb(lo, ack);
      begin
        repeat (60) @(posedge clk);
        cr(`I2CSP_OFS_STAT, 8'h07, 8'h03, "stat hi");
        cr(`I2CSP_OFS_BUF, 8'hFF, hi, "buf hi");
        wreg(`I2CSP_OFS_ADDR, lo);
      end
    join
    `CHK("ack lo", 1'b1, ack)
    fork
      wb(d1, ack);
      begin
        repeat (60) @(posedge clk);
        cr(`I2CSP_OFS_STAT, 8'h07, 8'h03, "stat lo");
        cr(`I2CSP_OFS_BUF, 8'hFF, lo, "buf lo");
        wreg(`I2CSP_OFS_ADDR, hi);
      end
    join
    `CHK("ack d10", 1'b1, ack)
    cr(`I2CSP_OFS_BUF, 8'hFF, d1, "buf d10");
    m.start();
    wb({hi[7:1], 1'b1}, ack);
    `CHK("ack rs hdr", 1'b1, ack)
    tx = 8'($urandom);
    fork
      m.xfer(8'hFF, 1'b1, q, ack);
      begin
        repeat (60) @(posedge clk);
        cr(`I2CSP_OFS_STAT, 8'h07, 8'h05, "stat rs");
        cr(`I2CSP_OFS_BUF, 8'hFF, {hi[7:1], 1'b1}, "buf rs");
        wreg(`I2CSP_OFS_BUF, tx);
        wreg(`I2CSP_OFS_CTRL, 8'h37);
      end
    join
    `CHK("tx rs data", tx, q)
    `CHK("ack rs slot", 1'b1, ack)
    m.stop();
    `CHK("stretch ok", 1'b0, stuck)
    $display("ten bit done");
    finish_test();
  end
endmodule
bind i2csp_top i2csp_checker u_chk (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pins(pins),
  .pins_out(pins_out));
